//--- hdl/scal_regs.sv
// synth and rx filter calibration test register bank
`timescale 1ns/1ns
`default_nettype none
`include "scal_params.svh"

module scal_regs
    import scal_pkg::*;
#(
    parameter int CAL_SHORT_CYC = (`SCAL_CAL_SHORT_NS + `SCAL_CLK_NS - 1)
                                  / `SCAL_CLK_NS,
    parameter int CAL_LONG_CYC = (`SCAL_CAL_LONG_NS + `SCAL_CLK_NS - 1)
                                 / `SCAL_CLK_NS
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // register port from the serial config interface
    input wire logic REG_WR_I,
    input wire logic [5:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    output logic [15:0] REG_RDATA_O,
    // radio state events
    input wire logic ENTER_RX_I,
    input wire logic ENTER_TX_I,
    input wire logic TX_SYNTH_CAL_STROBE_I,
    // analog calibration results, test controls and phase detector pulses
    input wire logic [5:0] OSC_CURRENT_MEAS_I,
    input wire logic RXF_CAL_DONE_I,
    input wire logic [6:0] RXF_CAP_MEAS_I,
    input wire logic [3:0] ANALOG_TEST_SELECT_I,
    input wire logic TUNE_NODE_TEST_DRIVE_I,
    input wire logic PD_UP_I,
    input wire logic PD_DN_I,
    // controls to the analog circuits
    output logic OSC_CAL_ACTIVE_O,
    output logic OSC_CAL_DONE_O,
    output logic LONG_FREQ_MEASURE_O,
    output logic [3:0] OSC_REF_CURRENT_O,
    output logic [1:0] OSC_CURRENT_CAL_RATE_O,
    output logic OSC_CURRENT_OVERRIDE_EN_O,
    output logic [5:0] OSC_CURRENT_OVERRIDE_A_O,
    output logic [5:0] OSC_CURRENT_OVERRIDE_B_O,
    output logic TUNE_NODE_OPEN_LOOP_O,
    output logic TUNE_NODE_EXT_DRIVE_O,
    output logic TUNE_NODE_OBSERVE_O,
    output logic [2:0] TUNE_NODE_DAC_VALUE_O,
    output logic PUMP_UP_O,
    output logic PUMP_DN_O,
    output logic PHASE_DET_LONG_DELAY_O,
    output logic [3:0] PUMP_CURRENT_O,
    output logic [6:0] RX_FILTER_CAP_O
);
    // ------------------------------------------------------------
    // input synchroniser for the tune node test drive
    // ------------------------------------------------------------
    logic ts_s1_reg;
    logic ts_s2_reg;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ts_s1_reg <= 1'b0;
            ts_s2_reg <= 1'b0;
        end else if (CE_I) begin
            ts_s1_reg <= TUNE_NODE_TEST_DRIVE_I;
            ts_s2_reg <= ts_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    scal_ctrl_t ctrl_reg;
    scal_osc_t osc_reg;
    scal_pump_t pump_reg;
    scal_rxf_t rxf_reg;

    logic wr_ctrl;
    logic wr_osc;
    logic wr_pump;
    logic wr_rxf;

    assign wr_ctrl = REG_WR_I && (REG_ADDR_I == `SCAL_ADDR_CTRL);
    assign wr_osc = REG_WR_I && (REG_ADDR_I == `SCAL_ADDR_OSC);
    assign wr_pump = REG_WR_I && (REG_ADDR_I == `SCAL_ADDR_PUMP);
    assign wr_rxf = REG_WR_I && (REG_ADDR_I == `SCAL_ADDR_RXF);

    // ------------------------------------------------------------
    // calibration sequencer
    // ------------------------------------------------------------
    scal_state_t state_reg;
    scal_state_t state_next;
    logic [15:0] cal_cnt_reg;
    logic [3:0] pump_cur_reg;
    logic cal_req;
    logic cal_end;
    logic [15:0] cal_len;
    logic step_tick;

    // transmit entry is skipped only when the host asked for it
    assign cal_req = ENTER_RX_I
                     || (ENTER_TX_I && !ctrl_reg.skip_tx_osc_cal)
                     || (TX_SYNTH_CAL_STROBE_I
                         && ctrl_reg.skip_tx_osc_cal);
    assign cal_len = ctrl_reg.long_freq_measure
                     ? 16'(CAL_LONG_CYC) : 16'(CAL_SHORT_CYC);
    assign cal_end = (state_reg == SCAL_CAL)
                     && (cal_cnt_reg == cal_len - 16'h0001);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SCAL_IDLE: if (cal_req) state_next = SCAL_CAL;
            SCAL_CAL: if (cal_end) state_next = SCAL_STEP;
            SCAL_STEP: begin
                if (cal_req)
                    state_next = SCAL_CAL;
                else if (pump_cur_reg <= pump_reg.pump_final_current)
                    state_next = SCAL_IDLE;
            end
            default: state_next = SCAL_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_reg <= SCAL_IDLE;
            cal_cnt_reg <= 16'h0000;
        end else if (CE_I) begin
            state_reg <= state_next;
            cal_cnt_reg <= (state_next == SCAL_CAL && state_reg == SCAL_CAL)
                           ? cal_cnt_reg + 16'h0001 : 16'h0000;
        end
    end

    scal_step_timer #(
        .W(6)
    ) u_step (
        .CLK_I(CLK_I),
        .RST_N_I(RST_N_I),
        .CE_I(CE_I),
        .run_i(state_reg == SCAL_STEP),
        .sel_i(pump_reg.pump_step_interval),
        .tick_o(step_tick)
    );

    // stepped pump current: loaded at cal end, lowered once per interval
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I)
            pump_cur_reg <= 4'hD;
        else if (CE_I) begin
            if (cal_end)
                pump_cur_reg <= pump_reg.pump_initial_current;
            else if (state_reg == SCAL_STEP && step_tick
                     && pump_cur_reg > pump_reg.pump_final_current)
                pump_cur_reg <= pump_cur_reg - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // register writes; result fields only follow calibration
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ctrl_reg <= `SCAL_RST_CTRL;
            osc_reg <= `SCAL_RST_OSC;
            pump_reg <= `SCAL_RST_PUMP;
            rxf_reg <= `SCAL_RST_RXF;
        end else if (CE_I) begin
            if (wr_ctrl)
                ctrl_reg <= REG_WDATA_I;
            if (wr_osc)
                osc_reg[15:6] <= {1'b0, REG_WDATA_I[14:6]};
            if (cal_end)
                osc_reg.osc_current_cal_result <= OSC_CURRENT_MEAS_I;
            if (wr_pump)
                pump_reg <= REG_WDATA_I;
            if (wr_rxf)
                rxf_reg[15:7] <= {1'b0, REG_WDATA_I[14:7]};
            if (RXF_CAL_DONE_I)
                rxf_reg.rx_filter_cap_result <= RXF_CAP_MEAS_I;
        end
    end

    // ------------------------------------------------------------
    // read mux; unmapped addresses read zero
    // ------------------------------------------------------------
    assign REG_RDATA_O = (REG_ADDR_I == `SCAL_ADDR_CTRL) ? ctrl_reg :
                         (REG_ADDR_I == `SCAL_ADDR_OSC) ? osc_reg :
                         (REG_ADDR_I == `SCAL_ADDR_PUMP) ? pump_reg :
                         (REG_ADDR_I == `SCAL_ADDR_RXF) ? rxf_reg : 16'h0000;

    // ------------------------------------------------------------
    // analog controls
    // ------------------------------------------------------------
    logic cal_on;
    logic test_mode_vc;
    logic pump_kill;

    assign cal_on = (state_reg == SCAL_CAL);
    assign OSC_CAL_ACTIVE_O = cal_on;
    assign OSC_CAL_DONE_O = cal_end;
    assign LONG_FREQ_MEASURE_O = ctrl_reg.long_freq_measure;
    assign OSC_REF_CURRENT_O = ctrl_reg.osc_ref_current;
    assign OSC_CURRENT_CAL_RATE_O = osc_reg.osc_current_cal_rate;
    assign OSC_CURRENT_OVERRIDE_EN_O = osc_reg.osc_current_override_en;
    assign OSC_CURRENT_OVERRIDE_A_O = osc_reg.osc_current_override_a;
    assign OSC_CURRENT_OVERRIDE_B_O = osc_reg.osc_current_override_en
                                      ? ctrl_reg.osc_current_const
                                      : 6'h00;

    // the external drive only applies in the vc analog test mode
    assign test_mode_vc = (ANALOG_TEST_SELECT_I == `SCAL_ANALOG_TEST_VC);
    assign TUNE_NODE_EXT_DRIVE_O = test_mode_vc && ts_s2_reg;
    assign TUNE_NODE_OBSERVE_O = test_mode_vc && !ts_s2_reg;
    assign TUNE_NODE_OPEN_LOOP_O = !TUNE_NODE_EXT_DRIVE_O
                                   && ctrl_reg.tune_node_open_loop;
    assign TUNE_NODE_DAC_VALUE_O = ctrl_reg.tune_node_dac_value;

    assign pump_kill = pump_reg.pump_pulse_mask
                       || (cal_on && pump_reg.pump_off_during_cal);
    // forced currents bypass the mask so a stuck pump can still be probed
    assign PUMP_UP_O = pump_reg.pump_force_source
                       || (PD_UP_I && !pump_kill);
    assign PUMP_DN_O = pump_reg.pump_force_sink
                       || (PD_DN_I && !pump_kill);
    assign PHASE_DET_LONG_DELAY_O = pump_reg.phase_det_long_delay;
    assign PUMP_CURRENT_O = pump_reg.pump_current_override_en
                            ? pump_reg.pump_initial_current
                            : pump_cur_reg;
    assign RX_FILTER_CAP_O = rxf_reg.rx_filter_cap_override_en
                             ? rxf_reg.rx_filter_cap_override
                             : rxf_reg.rx_filter_cap_result;
endmodule // scal_regs

`default_nettype wire

//--- hdl/scal_params.svh
// register offsets, reset values, analog test select code and timing for synth cal
`ifndef SCAL_PARAMS_SVH
`define SCAL_PARAMS_SVH

`define SCAL_ADDR_CTRL 6'h28
`define SCAL_ADDR_OSC 6'h29
`define SCAL_ADDR_PUMP 6'h2A
`define SCAL_ADDR_RXF 6'h2B

`define SCAL_RST_CTRL 16'h5002
`define SCAL_RST_OSC 16'h0600
`define SCAL_RST_PUMP 16'h82DD
`define SCAL_RST_RXF 16'h0000

`define SCAL_CAL_SHORT_NS 37000
`define SCAL_CAL_LONG_NS 57000
`define SCAL_CLK_NS 100
`define SCAL_STEP0_NS 250
`define SCAL_STEP1_NS 500
`define SCAL_STEP2_NS 1000
`define SCAL_STEP3_NS 4000

`define SCAL_ANALOG_TEST_VC 4'h7

`endif

//--- hdl/scal_pkg.sv
// types shared by the synth calibration register bank
package scal_pkg;

    typedef struct packed {
        logic skip_tx_osc_cal;
        logic long_freq_measure;
        logic [3:0] osc_ref_current;
        logic [5:0] osc_current_const;
        logic tune_node_open_loop;
        logic [2:0] tune_node_dac_value;
    } scal_ctrl_t;

    typedef struct packed {
        logic rsvd;
        logic [1:0] osc_current_cal_rate;
        logic osc_current_override_en;
        logic [5:0] osc_current_override_a;
        logic [5:0] osc_current_cal_result;
    } scal_osc_t;

    typedef struct packed {
        logic pump_off_during_cal;
        logic pump_current_override_en;
        logic pump_force_source;
        logic pump_force_sink;
        logic pump_pulse_mask;
        logic phase_det_long_delay;
        logic [1:0] pump_step_interval;
        logic [3:0] pump_final_current;
        logic [3:0] pump_initial_current;
    } scal_pump_t;

    typedef struct packed {
        logic rsvd;
        logic rx_filter_cap_override_en;
        logic [6:0] rx_filter_cap_override;
        logic [6:0] rx_filter_cap_result;
    } scal_rxf_t;

    typedef enum logic [1:0] {
        SCAL_IDLE = 2'b00,
        SCAL_CAL = 2'b01,
        SCAL_STEP = 2'b11
    } scal_state_t;

endpackage

//--- hdl/scal_step_timer.sv
// pump current step interval timer
`timescale 1ns/1ns
`default_nettype none
`include "scal_params.svh"

module scal_step_timer #(
    parameter int W = 6
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic run_i,
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    // each interval rounded down to whole cycles, interval 0 at least one
    localparam int C0 = (`SCAL_STEP0_NS / `SCAL_CLK_NS) < 1 ? 1
                        : (`SCAL_STEP0_NS / `SCAL_CLK_NS);
    localparam int C1 = `SCAL_STEP1_NS / `SCAL_CLK_NS;
    localparam int C2 = `SCAL_STEP2_NS / `SCAL_CLK_NS;
    localparam int C3 = `SCAL_STEP3_NS / `SCAL_CLK_NS;

    logic [W-1:0] cnt_reg;
    logic [W-1:0] limit;

    assign limit = (sel_i == 2'h0) ? W'(C0 - 1) :
                   (sel_i == 2'h1) ? W'(C1 - 1) :
                   (sel_i == 2'h2) ? W'(C2 - 1) : W'(C3 - 1);
    assign tick_o = run_i && (cnt_reg >= limit);

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I)
            cnt_reg <= '0;
        else if (CE_I)
            cnt_reg <= (!run_i || tick_o) ? '0 : cnt_reg + W'(1);
    end
endmodule // scal_step_timer

`default_nettype wire

//--- sim/scal_regs_assertions.sv
// concurrent checks on the synth calibration register bank ports
`timescale 1ns/1ns
`default_nettype none

module scal_regs_assertions #(
    parameter int CAL_SHORT_CYC = 370,
    parameter int CAL_LONG_CYC = 570
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic REG_WR_I,
    input wire logic [5:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic [15:0] REG_RDATA_O,
    input wire logic ENTER_RX_I,
    input wire logic [5:0] OSC_CURRENT_MEAS_I,
    input wire logic RXF_CAL_DONE_I,
    input wire logic [6:0] RXF_CAP_MEAS_I,
    input wire logic OSC_CAL_ACTIVE_O,
    input wire logic OSC_CAL_DONE_O,
    input wire logic LONG_FREQ_MEASURE_O,
    input wire logic [3:0] PUMP_CURRENT_O,
    input wire logic [6:0] RX_FILTER_CAP_O
);
    logic [15:0] act_cnt_reg;
    wire rd29 = REG_ADDR_I == 6'h29;
    wire rd2b = REG_ADDR_I == 6'h2B;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    // cycles spent calibrating so far, frozen with the clock enable
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || !OSC_CAL_ACTIVE_O) begin
            act_cnt_reg <= 16'h0000;
        end else if (CE_I) begin
            act_cnt_reg <= act_cnt_reg + 16'h0001;
        end
    end

    a_cal_start_rx: assert property (
        ENTER_RX_I && CE_I && !OSC_CAL_ACTIVE_O |=> OSC_CAL_ACTIVE_O)
        else $error("cal did not start on receive entry");
    a_cal_length: assert property (OSC_CAL_DONE_O |-> act_cnt_reg ==
        (LONG_FREQ_MEASURE_O ? CAL_LONG_CYC : CAL_SHORT_CYC) - 1)
        else $error("cal length wrong");
    a_done_once: assert property (
        OSC_CAL_DONE_O && CE_I |=> !OSC_CAL_DONE_O && !OSC_CAL_ACTIVE_O)
        else $error("cal did not end after done");
    a_unmapped_zero: assert property (
        REG_ADDR_I < 6'h28 || REG_ADDR_I > 6'h2B |-> REG_RDATA_O == 16'h0000)
        else $error("unmapped read not zero");
    a_write_back: assert property (REG_WR_I && CE_I &&
        REG_ADDR_I == 6'h28 ##1 REG_ADDR_I == 6'h28 |->
        REG_RDATA_O == $past(REG_WDATA_I)) else $error("readback wrong");
    a_result_ro: assert property (REG_WR_I && CE_I && rd29 &&
        !OSC_CAL_DONE_O ##1 rd29 |-> $stable(REG_RDATA_O[5:0]))
        else $error("write changed osc result");
    a_osc_capture: assert property (OSC_CAL_DONE_O && CE_I ##1
        rd29 |-> REG_RDATA_O[5:0] == $past(OSC_CURRENT_MEAS_I))
        else $error("osc result not captured");
    a_rxf_capture: assert property (RXF_CAL_DONE_I && CE_I &&
        rd2b ##1 rd2b |-> REG_RDATA_O[6:0] == $past(RXF_CAP_MEAS_I))
        else $error("filter result not captured");
    a_cap_select: assert property (rd2b |-> RX_FILTER_CAP_O ==
        (REG_RDATA_O[14] ? REG_RDATA_O[13:7] : REG_RDATA_O[6:0]))
        else $error("filter cap select wrong");
    a_pump_override: assert property (
        REG_ADDR_I == 6'h2A && REG_RDATA_O[14] |->
        PUMP_CURRENT_O == REG_RDATA_O[3:0]) else $error("pump override wrong");

    c_cal_done: cover property (OSC_CAL_DONE_O);
    c_rxf_done: cover property (RXF_CAL_DONE_I && rd2b);
    c_long_cal: cover property (OSC_CAL_DONE_O && LONG_FREQ_MEASURE_O);
endmodule // scal_regs_assertions

bind scal_regs scal_regs_assertions #(
    .CAL_SHORT_CYC(CAL_SHORT_CYC), .CAL_LONG_CYC(CAL_LONG_CYC)
) u_chk (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .REG_WR_I(REG_WR_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_RDATA_O(REG_RDATA_O), .ENTER_RX_I(ENTER_RX_I),
    .OSC_CURRENT_MEAS_I(OSC_CURRENT_MEAS_I), .RXF_CAL_DONE_I(RXF_CAL_DONE_I),
    .RXF_CAP_MEAS_I(RXF_CAP_MEAS_I), .OSC_CAL_ACTIVE_O(OSC_CAL_ACTIVE_O),
    .OSC_CAL_DONE_O(OSC_CAL_DONE_O),
    .LONG_FREQ_MEASURE_O(LONG_FREQ_MEASURE_O),
    .PUMP_CURRENT_O(PUMP_CURRENT_O), .RX_FILTER_CAP_O(RX_FILTER_CAP_O)
);
`default_nettype wire

//--- sim/synth_cal_test_regs_bench.sv
// self-checking bench for the synth calibration register bank
`timescale 1ns/1ns
`default_nettype none

module synth_cal_test_regs_bench;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0;
    logic e_rx = 1'b0, e_tx = 1'b0, stb = 1'b0, rxf_done = 1'b0;
    logic tdrv = 1'b0, pd_up = 1'b0, pd_dn = 1'b0;
    logic [5:0] addr = 6'h00, osc_meas = 6'h2A, ova, ovb;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [6:0] rxf_meas = 7'h00, cap;
    logic [3:0] atest = 4'h0, ref_cur, pcur;
    logic [1:0] rate;
    logic act, done, lng, ol, ext, up, dn, pdl, obs, oven;
    logic [2:0] dacv;
    int n_fail = 0, total_checks = 0;

    scal_regs #(.CAL_SHORT_CYC(8), .CAL_LONG_CYC(12)) i_dut (
        .CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .REG_WR_I(wr),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .ENTER_RX_I(e_rx), .ENTER_TX_I(e_tx), .TX_SYNTH_CAL_STROBE_I(stb),
        .OSC_CURRENT_MEAS_I(osc_meas), .RXF_CAL_DONE_I(rxf_done),
        .RXF_CAP_MEAS_I(rxf_meas), .ANALOG_TEST_SELECT_I(atest),
        .TUNE_NODE_TEST_DRIVE_I(tdrv), .PD_UP_I(pd_up), .PD_DN_I(pd_dn),
        .OSC_CAL_ACTIVE_O(act), .OSC_CAL_DONE_O(done),
        .LONG_FREQ_MEASURE_O(lng), .OSC_REF_CURRENT_O(ref_cur),
        .OSC_CURRENT_CAL_RATE_O(rate), .OSC_CURRENT_OVERRIDE_EN_O(oven),
        .OSC_CURRENT_OVERRIDE_A_O(ova), .OSC_CURRENT_OVERRIDE_B_O(ovb),
        .TUNE_NODE_OPEN_LOOP_O(ol), .TUNE_NODE_EXT_DRIVE_O(ext),
        .TUNE_NODE_OBSERVE_O(obs), .TUNE_NODE_DAC_VALUE_O(dacv),
        .PUMP_UP_O(up),
        .PUMP_DN_O(dn), .PHASE_DET_LONG_DELAY_O(pdl),
        .PUMP_CURRENT_O(pcur), .RX_FILTER_CAP_O(cap)
    );

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // write taken at the second edge; returns with outputs settled
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        @(negedge clk);
        chk("read data", e, rdata);
    endtask

    // ev 0 receive, 1 transmit, 2 strobe; n expected active cycles
    task automatic cal(input int ev, input int n);
        int c = 0;
        @(posedge clk);
        e_rx <= (ev == 0);
        e_tx <= (ev == 1);
        stb <= (ev == 2);
        addr <= 6'h29;
        @(posedge clk);
        e_rx <= 1'b0;
        e_tx <= 1'b0;
        stb <= 1'b0;
        repeat (20) begin
            @(negedge clk);
            if (act === 1'b1) c++;
        end
        chk("cal cycles", n[15:0], c[15:0]);
    endtask

    task automatic t_reset;
        rd_chk(6'h28, 16'h5002);
        rd_chk(6'h29, 16'h0600);
        rd_chk(6'h2A, 16'h82DD);
        rd_chk(6'h2B, 16'h0000);
        rd_chk(6'h2C, 16'h0000);
        chk("pump current", 16'd13, pcur);
        chk("ref current", 16'd4, ref_cur);
        chk("long measure", 16'd1, lng);
        chk("dac value", 16'd2, dacv);
    endtask

    task automatic t_regs;
        wr_reg(6'h28, 16'h0158);
        rd_chk(6'h28, 16'h0158);
        chk("open loop", 16'd1, ol);
        // clock enable low: the write must not land
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(6'h28, 16'h0000);
        rd_chk(6'h28, 16'h0158);
        @(posedge clk);
        ce <= 1'b1;
        wr_reg(6'h29, 16'h7FFF);
        rd_chk(6'h29, 16'h7FC0);
        chk("override b", 16'h15, ovb);
        chk("override a", 16'h3F, ova);
        chk("override en", 16'd1, oven);
        chk("cal rate", 16'd3, rate);
        wr_reg(6'h29, 16'h0600);
        wr_reg(6'h2B, 16'h7FFF);
        rd_chk(6'h2B, 16'h7F80);
        chk("filter cap", 16'h7F, cap);
        wr_reg(6'h2B, 16'h0000);
    endtask

    task automatic t_cal;
        wr_reg(6'h28, 16'h1002);
        cal(0, 8);
        cal(1, 8);
        cal(2, 0);
        rd_chk(6'h29, 16'h062A);
        wr_reg(6'h28, 16'h5002);
        cal(0, 12);
        wr_reg(6'h28, 16'h9002);
        cal(1, 0);
        cal(2, 8);
        cal(0, 8);
    endtask

    task automatic t_pump;
        int k = 0;
        int e;
        wr_reg(6'h2A, 16'h0025);
        @(posedge clk);
        e_rx <= 1'b1;
        @(posedge clk);
        e_rx <= 1'b0;
        while (done !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        if (k == 50) begin
            n_fail++;
            stop_test();
        end
        // interval code 0 is two cycles per step
        for (int i = 1; i < 10; i++) begin
            @(negedge clk);
            e = 5 - (i - 1) / 2;
            if (e < 2) e = 2;
            chk("stepped current", e[15:0], pcur);
        end
        wr_reg(6'h2A, 16'h4025);
        chk("override current", 16'd5, pcur);
        wr_reg(6'h2A, 16'h3800);
        chk("forced up dn", 16'h3, {up, dn});
        @(posedge clk);
        pd_up <= 1'b1;
        pd_dn <= 1'b1;
        wr_reg(6'h2A, 16'h0800);
        chk("masked up dn", 16'h0, {up, dn});
        wr_reg(6'h2A, 16'h0400);
        chk("pd pulses", 16'h3, {up, dn});
        chk("long delay", 16'd1, pdl);
        wr_reg(6'h2A, 16'h8000);
        @(posedge clk);
        e_rx <= 1'b1;
        @(posedge clk);
        e_rx <= 1'b0;
        @(negedge clk);
        chk("pump in cal", 16'h4, {act, up, dn});
        repeat (20) @(posedge clk);
    endtask

    task automatic t_rxf;
        @(posedge clk);
        rxf_meas <= 7'h55;
        rxf_done <= 1'b1;
        addr <= 6'h2B;
        @(posedge clk);
        rxf_done <= 1'b0;
        rd_chk(6'h2B, 16'h0055);
        chk("filter cap", 16'h55, cap);
        wr_reg(6'h2B, 16'h4880);
        rd_chk(6'h2B, 16'h48D5);
        chk("filter cap", 16'h11, cap);
    endtask

    task automatic t_tune;
        @(posedge clk);
        atest <= 4'h7;
        tdrv <= 1'b1;
        repeat (4) @(negedge clk);
        chk("ext drive", 16'd1, ext);
        @(posedge clk);
        atest <= 4'h0;
        @(negedge clk);
        chk("ext drive", 16'd0, ext);
        chk("observe", 16'd0, obs);
        @(posedge clk);
        atest <= 4'h7;
        tdrv <= 1'b0;
        repeat (4) @(negedge clk);
        chk("observe", 16'd1, obs);
        chk("ext drive", 16'd0, ext);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_cal();
        t_pump();
        t_rxf();
        t_tune();
        stop_test();
    end
endmodule // synth_cal_test_regs_bench
`default_nettype wire
